// >>> rtl/rpdc_top.sv
// reset merging, stabilisation wait and stop/idle sequencing
// What this block does
// - four reset sources: por, pin, watchdog, low supply
// - option bit picks supply or pin reset
// - reset pin synchronised before use
// - wait 2**19 oscillator periods before running
// - reset loads control registers with defaults
// - watchdog overflow raises internal reset
// - low supply holds static reset
// - nibble 1010 disables the watchdog reset
// - reset masks interrupts, watchdog on, ports input
// - vector at 0100h fetched after stabilisation
// - opcode 7fh enters stop, oscillator halted
// - reset out of stop restores defaults
// - only external irqs wake from stop
// - irq wake keeps control registers and divider
// - serve wake irq, resume after stop
// - opcode 6fh enters idle, cpu clock gated
// - ports keep direction during idle
// - reset releases idle like stop
// - any enabled irq releases idle
// - wake enable bit gates stop release
// - divider selects /1 /2 /8 /16
`timescale 1ns/100ps

module rpdc_top #(
    parameter int STAB_CYCLES = rpdc_pkg::STAB_PER,
    parameter int WDT_CYCLES  = rpdc_pkg::WDT_PER
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        optInternalReset,
    input  wire logic        resetPinIn,
    input  wire logic        lowVoltage,
    input  wire logic        extIrqA,
    input  wire logic        extIrqB,
    input  wire logic        irqPending,
    input  wire logic        opValid,
    input  wire logic [7:0]  opCode,
    output logic             sysReset,
    output logic             irqDisable,
    output logic             portsInput,
    output logic             portDirHold,
    output logic             resetPinGpio,
    output logic             oscRun,
    output logic             periphClkEn,
    output logic             cpuClkEn,
    output logic             fetchEnable,
    output logic             vectorFetch,
    output logic [15:0]      vectorAddr,
    output logic             wakeService,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // state and decoded terms
    // ------------------------------------------------------------
    rpdc_pkg::rpdc_state_t q;          // registered state
    rpdc_pkg::rpdc_state_t n;          // next state
    logic                  pinReset;   // synchronised pin low, pin mode
    logic                  lowSupply;  // supply low, internal mode
    logic                  wdtOn;      // watchdog counting
    logic                  wdtOvf;     // watchdog overflow this cycle
    logic                  resetReq;   // pin, watchdog or low supply reset active
    logic                  doWrite;    // address and data both held
    logic [7:0]            wIdx;       // write register index
    logic [7:0]            rIdx;       // read register index
    logic [3:0]            divMask;    // terminal mask of the divider
    logic [3:0]            causeClr;   // cause bits cleared by software

    // wake interval for a select code, shortened by two bits per step
    function automatic logic [rpdc_pkg::CNT_W-1:0] stabLen(input logic [1:0] sel);
        stabLen = rpdc_pkg::CNT_W'((STAB_CYCLES >> {sel, 1'b0}) - 1);
    endfunction

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    // pin is a reset only when the option leaves the supply detector unused
    assign pinReset     = !optInternalReset && !q.pin2;
    assign lowSupply    = optInternalReset && lowVoltage;
    assign resetPinGpio = optInternalReset;
    // watchdog runs while cpu or timers run, unless keyed off
    assign wdtOn  = (q.btc[7:4] != rpdc_pkg::WDT_KEY) &&
                    (q.mode == rpdc_pkg::ST_RUN || q.mode == rpdc_pkg::ST_IDLE);
    assign wdtOvf = wdtOn && (q.wdtCnt == rpdc_pkg::CNT_W'(WDT_CYCLES - 1));
    assign resetReq = pinReset || lowSupply || wdtOvf;

    // bus decode
    assign doWrite  = q.awHeld && q.wHeld && !q.bvalid;
    assign wIdx     = q.awAddr[9:2];
    assign rIdx     = s_axi_araddr[9:2];
    assign causeClr = (doWrite && q.wStrb && wIdx == rpdc_pkg::IDX_STAT) ? q.wData[3:0] : 4'h0;

    // divider terminal mask per select code
    always_comb begin
        case (q.ckcDiv)
            2'b00:   divMask = 4'hf;
            2'b01:   divMask = 4'h7;
            2'b10:   divMask = 4'h1;
            default: divMask = 4'h0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n           = q;
        n.fetchKick = 1'b0;
        n.wakeKick  = 1'b0;
        // two-stage pin synchroniser
        n.pin1      = resetPinIn;
        n.pin2      = q.pin1;
        // free running divider counter, frozen in stop
        if (q.mode != rpdc_pkg::ST_STOP) begin
            n.divCnt = q.divCnt + 4'h1;
        end
        // watchdog counter
        if (wdtOn) begin
            n.wdtCnt = q.wdtCnt + rpdc_pkg::CNT_W'(1);
        end else begin
            n.wdtCnt = '0;
        end
        // write address and data captured in either order
        if (s_axi_awvalid && s_axi_awready) begin
            n.awHeld = 1'b1;
            n.awAddr = s_axi_awaddr[rpdc_pkg::ADDR_W-1:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.wHeld = 1'b1;
            n.wData = s_axi_wdata[7:0];
            n.wStrb = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // write performed once both halves are held
        if (doWrite) begin
            n.awHeld = 1'b0;
            n.wHeld  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = rpdc_pkg::RESP_OK;
            case (wIdx)
                rpdc_pkg::IDX_BTC: begin
                    if (q.wStrb) begin
                        n.btc = {q.wData[7:2], 2'b00};
                        if (q.wData[rpdc_pkg::BTC_CLR]) begin
                            n.wdtCnt = '0;
                        end
                    end
                end
                rpdc_pkg::IDX_CKC: begin
                    if (q.wStrb) begin
                        n.ckcWake = q.wData[rpdc_pkg::CKC_WAKE];
                        n.ckcDiv  = q.wData[rpdc_pkg::CKC_DIV +: 2];
                    end
                end
                rpdc_pkg::IDX_STAT: begin
                    // cause bits are write one to clear
                end
                default: begin
                    n.bresp = rpdc_pkg::RESP_ERR;
                end
            endcase
        end
        // read answered one cycle after the address is taken
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp  = rpdc_pkg::RESP_OK;
            case (rIdx)
                rpdc_pkg::IDX_STAT: n.rdata = {1'b0, q.mode, q.cause};
                rpdc_pkg::IDX_BTC:  n.rdata = q.btc;
                rpdc_pkg::IDX_CKC:  n.rdata = {q.ckcWake, 2'b00, q.ckcDiv, 3'b000};
                default: begin
                    n.rdata = 8'h00;
                    n.rresp = rpdc_pkg::RESP_ERR;
                end
            endcase
        end
        // reset cause: a new cause wins over a clear
        n.cause = (q.cause & ~causeClr) | {lowSupply, wdtOvf, pinReset, 1'b0};
        // power mode sequencing, reset first in every mode
        if (resetReq) begin
            n.mode = rpdc_pkg::ST_RESET;
        end else begin
            case (q.mode)
                rpdc_pkg::ST_RESET: begin
                    n.mode    = rpdc_pkg::ST_STAB;
                    n.stabCnt = rpdc_pkg::CNT_W'(STAB_CYCLES - 1);
                end
                rpdc_pkg::ST_STAB, rpdc_pkg::ST_WAKE: begin
                    if (q.stabCnt == '0) begin
                        n.mode      = rpdc_pkg::ST_RUN;
                        n.fetchKick = (q.mode == rpdc_pkg::ST_STAB);
                        n.wakeKick  = (q.mode == rpdc_pkg::ST_WAKE);
                    end else begin
                        n.stabCnt = q.stabCnt - rpdc_pkg::CNT_W'(1);
                    end
                end
                rpdc_pkg::ST_RUN: begin
                    if (opValid && opCode == rpdc_pkg::OP_STOP) begin
                        n.mode = rpdc_pkg::ST_STOP;
                    end else if (opValid && opCode == rpdc_pkg::OP_IDLE) begin
                        n.mode = rpdc_pkg::ST_IDLE;
                    end
                end
                rpdc_pkg::ST_STOP: begin
                    // clock-free external inputs only, divider untouched
                    if (q.ckcWake && (extIrqA || extIrqB)) begin
                        n.mode    = rpdc_pkg::ST_WAKE;
                        n.stabCnt = stabLen(q.btc[rpdc_pkg::BTC_SEL +: 2]);
                    end
                end
                rpdc_pkg::ST_IDLE: begin
                    if (irqPending) begin
                        n.mode     = rpdc_pkg::ST_RUN;
                        n.wakeKick = 1'b1;
                    end
                end
                default: begin
                    n.mode = rpdc_pkg::ST_RESET;
                end
            endcase
        end
        // control registers held at defaults throughout reset
        if (resetReq || q.mode == rpdc_pkg::ST_RESET) begin
            n.btc     = rpdc_pkg::BTC_RST;
            n.ckcWake = rpdc_pkg::WAKE_RST;
            n.ckcDiv  = rpdc_pkg::DIV_16;
            n.wdtCnt  = '0;
        end
        // power-on reset
        if (!rst_n) begin
            n         = '0;
            n.ckcWake = rpdc_pkg::WAKE_RST;
            n.cause   = rpdc_pkg::CAUSE_POR;
            // synchroniser starts at the idle pin level, no false pin reset
            n.pin1    = 1'b1;
            n.pin2    = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        q <= n;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sysReset    = (q.mode == rpdc_pkg::ST_RESET);
    assign irqDisable  = sysReset || q.mode == rpdc_pkg::ST_STAB;
    assign portsInput  = irqDisable;
    assign portDirHold = (q.mode == rpdc_pkg::ST_IDLE);
    assign oscRun      = (q.mode != rpdc_pkg::ST_STOP);
    assign periphClkEn = oscRun;
    assign cpuClkEn    = (q.mode == rpdc_pkg::ST_RUN) &&
                         ((q.divCnt & divMask) == divMask);
    assign fetchEnable = (q.mode == rpdc_pkg::ST_RUN);
    assign vectorFetch = q.fetchKick;
    assign vectorAddr  = rpdc_pkg::RST_VEC;
    assign wakeService = q.wakeKick;
    // bus handshakes
    assign s_axi_awready = !q.awHeld && !q.bvalid;
    assign s_axi_wready  = !q.wHeld && !q.bvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rdata   = {24'h000000, q.rdata};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    anyReset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        resetReq |=> sysReset ##1 (sysReset || q.mode == rpdc_pkg::ST_STAB))
        else $error("reset source did not reach reset");

    pinSync_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!optInternalReset && !resetPinIn)[*3] |=> sysReset)
        else $error("held reset pin not seen after sync");

    supplyHold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (optInternalReset && lowVoltage) |=> sysReset && !fetchEnable)
        else $error("low supply did not hold reset");

    wdtKey_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.btc[7:4] == rpdc_pkg::WDT_KEY) |-> !wdtOvf)
        else $error("watchdog fired while keyed off");

    defaults_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sysReset |=> (q.ckcDiv == rpdc_pkg::DIV_16 && q.ckcWake && q.btc == 8'h00))
        else $error("control registers not at defaults");

    vecFetch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(fetchEnable) |-> (vectorFetch == ($past(q.mode) == rpdc_pkg::ST_STAB)))
        else $error("vector fetch mismatched to stabilisation end");

    stopEnter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fetchEnable && opValid && opCode == rpdc_pkg::OP_STOP && !resetReq)
        |=> !oscRun && !cpuClkEn)
        else $error("stop opcode did not halt oscillator");

    stopWake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!oscRun && !resetReq && !(q.ckcWake && (extIrqA || extIrqB))) |=> !oscRun)
        else $error("stop left without external wake");

    wakeDiv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!oscRun ##1 q.mode == rpdc_pkg::ST_WAKE) |-> $stable(q.ckcDiv) && $stable(q.btc))
        else $error("irq wake changed control registers");

    idleEnter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fetchEnable && opValid && opCode == rpdc_pkg::OP_IDLE && !resetReq)
        |=> portDirHold && !cpuClkEn && oscRun)
        else $error("idle opcode did not gate cpu clock");

    idleWake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (portDirHold && irqPending && !resetReq) |=> wakeService && fetchEnable)
        else $error("enabled irq did not release idle");

    resetMask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(sysReset) |-> irqDisable && portsInput && !fetchEnable)
        else $error("reset release lost masking");

endmodule // rpdc_top

// >>> rtl/rpdc_pkg.sv
// constants, register map and state types of the reset and power-down control
package rpdc_pkg;

    // ------------------------------------------------------------
    // clock and interval constants
    // ------------------------------------------------------------
    localparam int CLK_HZ     = 40_000_000; // core_clk is the oscillator clock
    localparam int STAB_LOG2  = 19;         // stabilisation: 2**19 oscillator periods
    localparam int STAB_PER   = 1 << STAB_LOG2;
    localparam int WDT_LOG2   = 20;         // watchdog overflow period, power of two
    localparam int WDT_PER    = 1 << WDT_LOG2;
    localparam int CNT_W      = 21;         // width of both long counters

    // ------------------------------------------------------------
    // register map: index, byte address is four times the index
    // ------------------------------------------------------------
    localparam int         ADDR_W   = 10;
    localparam logic [7:0] IDX_STAT = 8'h00; // mode and reset cause
    localparam logic [7:0] IDX_BTC  = 8'hd3; // basic_timer_control
    localparam logic [7:0] IDX_CKC  = 8'hd4; // clock_divider_control

    // field positions and reset values
    localparam int         BTC_CLR   = 1;     // write one refreshes the watchdog
    localparam int         BTC_SEL   = 2;     // two bits, wake interval select
    localparam int         CKC_WAKE  = 7;     // external interrupt wake enable
    localparam int         CKC_DIV   = 3;     // two bits, cpu clock divider
    localparam logic [7:0] BTC_RST   = 8'h00;
    localparam logic       WAKE_RST  = 1'b1;
    localparam logic [1:0] DIV_16    = 2'b00; // 01 /8, 10 /2, 11 /1
    localparam logic [3:0] WDT_KEY   = 4'ha;  // upper nibble that stops the watchdog
    localparam logic [3:0] CAUSE_POR = 4'h1;  // cause bits: por, pin, wdt, low supply

    // opcodes and vector
    localparam logic [7:0]  OP_STOP = 8'h7f;
    localparam logic [7:0]  OP_IDLE = 8'h6f;
    localparam logic [15:0] RST_VEC = 16'h0100;

    // bus responses
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_STAB  = 3'b001,
        ST_RUN   = 3'b010,
        ST_STOP  = 3'b011,
        ST_IDLE  = 3'b100,
        ST_WAKE  = 3'b101
    } rpdc_mode_t;

    typedef struct packed {
        rpdc_mode_t        mode;
        logic [7:0]        btc;
        logic              ckcWake;
        logic [1:0]        ckcDiv;
        logic [CNT_W-1:0]  stabCnt;
        logic [CNT_W-1:0]  wdtCnt;
        logic [3:0]        divCnt;
        logic [3:0]        cause;
        logic              pin1;
        logic              pin2;
        logic              fetchKick;
        logic              wakeKick;
        logic              awHeld;
        logic              wHeld;
        logic [ADDR_W-1:0] awAddr;
        logic [7:0]        wData;
        logic              wStrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [7:0]        rdata;
        logic [1:0]        rresp;
    } rpdc_state_t;

endpackage

// >>> tb/rpdc_pin_model.sv
// far-side model: external reset circuit and the two interrupt pins
`timescale 1ns/100ps

module rpdc_pin_model #(
    parameter int HOLD = 64  // low time of a pin reset, oscillator periods
) (
    input  wire logic       core_clk,
    input  wire logic       pinReq,
    input  wire logic [1:0] irqReq,
    output logic            resetPinIn,
    output logic            extIrqA,
    output logic            extIrqB
);
    int holdCnt = 0;  // cycles the pin still stays low

    // pin held low for HOLD oscillator periods after each request
    always @(posedge core_clk) begin
        if (pinReq === 1'h1) holdCnt <= HOLD;
        else if (holdCnt > 0) holdCnt <= holdCnt - 1;
    end

    // released pin goes to its pull-up level
    assign resetPinIn = (holdCnt == 0);
    // interrupt levels only while requested, low otherwise
    assign extIrqA    = irqReq[0];
    assign extIrqB    = irqReq[1];
endmodule // rpdc_pin_model

// >>> tb/tb_top.sv
// self-checking bench for the reset and power-down control
`timescale 1ns/100ps

module tb_top;
    localparam int STAB = 64;    // shortened stabilisation count
    localparam int WDT  = 1024;  // shortened watchdog period
    logic        core_clk = 1'h0, rst_n = 1'h0, optInternalReset = 1'h0;
    logic        lowVoltage = 1'h0, irqPending = 1'h0, opValid = 1'h0, pinReq = 1'h0;
    logic [7:0]  opCode = 8'h00;
    logic [1:0]  irqReq = 2'h0;
    logic        resetPinIn, extIrqA, extIrqB, sysReset, irqDisable, portsInput;
    logic        portDirHold, resetPinGpio, oscRun, periphClkEn, cpuClkEn;
    logic        fetchEnable, vectorFetch, wakeService;
    logic [15:0] vectorAddr;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        rstSeen = 1'h0;  // any reset seen while waiting
    int          bad_count = 0, compares = 0, stabN = 0;

    always #12.5 core_clk = ~core_clk;

    rpdc_pin_model #(.HOLD(STAB)) pins_u (.core_clk, .pinReq, .irqReq, .resetPinIn,
        .extIrqA, .extIrqB);

    rpdc_top #(.STAB_CYCLES(STAB), .WDT_CYCLES(WDT)) dut_u (.core_clk, .rst_n,
        .optInternalReset, .resetPinIn, .lowVoltage, .extIrqA, .extIrqB, .irqPending,
        .opValid, .opCode, .sysReset, .irqDisable, .portsInput, .portDirHold,
        .resetPinGpio, .oscRun, .periphClkEn, .cpuClkEn, .fetchEnable, .vectorFetch,
        .vectorAddr, .wakeService, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // n edges, noting any reset
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge core_clk);
            if (sysReset === 1'h1) rstSeen = 1'h1;
        end
    endtask

    // one write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        rs = s_axi_bresp;
    endtask

    // one read, data and response kept in rd and rs
    task automatic rdr(input logic [11:0] a);
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    // one executed instruction
    task automatic op(input logic [7:0] c);
        @(posedge core_clk);
        opValid <= 1'h1;
        opCode  <= c;
        @(posedge core_clk);
        opValid <= 1'h0;
    endtask

    // wait for run, counting cycles out of reset but not yet fetching
    task automatic run_wait();
        stabN = 0;
        for (int i = 0; i < 4 * STAB + 64 && fetchEnable !== 1'h1; i++) begin
            if (sysReset === 1'h0) stabN++;
            cyc(1);
        end
    endtask

    task automatic wait_rst();
        for (int i = 0; i < WDT + 64 && sysReset !== 1'h1; i++) cyc(1);
    endtask

    task automatic close_out();
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic boot_s();
        rst_n <= 1'h1;
        run_wait();
        chk("stabCycles", STAB, stabN);
        chk("vectorFetch", 1, vectorFetch);
        chk("vectorAddr", 16'h0100, vectorAddr);
        rdr(12'h350);
        chk("ckcDefault", 32'h80, rd);
        rdr(12'h34c);
        chk("btcDefault", 32'h0, rd);
        rdr(12'h004);
        chk("unmappedResp", 2'h2, rs);
        wr(12'h004, 32'h0);
        chk("wrUnmapped", 2'h2, rs);
    endtask

    // overflow resets, then the key stops it
    task automatic wdt_s();
        wait_rst();
        chk("wdtReset", 1, sysReset);
        run_wait();
        chk("wdtStab", STAB, stabN);
        rdr(12'h000);
        chk("statWdt", 32'h25, rd);
        wr(12'h34c, 32'ha0);
        chk("btcResp", 2'h0, rs);
        rstSeen = 1'h0;
        cyc(WDT + 64);
        chk("wdtKeyed", 0, rstSeen);
    endtask

    // stop entry, idle-type irq ignored, each external pin wakes
    task automatic stop_s();
        wr(12'h350, 32'h98);
        wr(12'h34c, 32'ha4);
        for (int k = 1; k < 3; k++) begin
            op(8'h7f);
            cyc(1);
            chk("oscRun", 0, oscRun);
            chk("periphClkEn", 0, periphClkEn);
            irqPending <= 1'h1;
            cyc(8);
            chk("stopHeld", 0, fetchEnable);
            irqPending <= 1'h0;
            irqReq     <= k[1:0];
            rstSeen = 1'h0;
            run_wait();
            irqReq <= 2'h0;
            chk("wakeLen", STAB / 4 + 2, stabN);
            chk("wakeService", 1, wakeService);
            chk("noReset", 0, rstSeen);
            cyc(1);
            chk("cpuClkEn", 1, cpuClkEn);
        end
        rdr(12'h350);
        chk("ckcKept", 32'h98, rd);
    endtask

    task automatic idle_s();
        op(8'h6f);
        cyc(5);
        chk("portDirHold", 1, portDirHold);
        chk("cpuClkEn", 0, cpuClkEn);
        chk("oscRun", 1, oscRun);
        irqPending <= 1'h1;
        run_wait();
        irqPending <= 1'h0;
        chk("idleWake", 1, wakeService);
        rdr(12'h350);
        chk("ckcIdle", 32'h98, rd);
    endtask

    // wake disabled: pins ignored, pin reset restores defaults
    task automatic pin_s();
        wr(12'h350, 32'h18);
        op(8'h7f);
        irqReq <= 2'h3;
        cyc(STAB);
        chk("wakeOff", 0, fetchEnable);
        irqReq <= 2'h0;
        pinReq <= 1'h1;
        cyc(1);
        pinReq <= 1'h0;
        wait_rst();
        chk("pinReset", 1, sysReset);
        run_wait();
        chk("pinStab", STAB, stabN);
        chk("pinVector", 1, vectorFetch);
        rdr(12'h350);
        chk("ckcPin", 32'h80, rd);
    endtask

    task automatic supply_s();
        optInternalReset <= 1'h1;
        lowVoltage       <= 1'h1;
        cyc(STAB + 8);
        chk("resetPinGpio", 1, resetPinGpio);
        chk("supplyHeld", 1, sysReset);
        lowVoltage <= 1'h0;
        run_wait();
        chk("supplyStab", STAB, stabN);
        rstSeen = 1'h0;
        pinReq <= 1'h1;
        cyc(1);
        pinReq <= 1'h0;
        cyc(STAB + 8);
        chk("pinIgnored", 0, rstSeen);
    endtask

    initial begin
        cyc(2);
        chk("sysReset", 1, sysReset);
        chk("irqDisable", 1, irqDisable);
        chk("portsInput", 1, portsInput);
        boot_s();
        wdt_s();
        stop_s();
        idle_s();
        pin_s();
        supply_s();
        close_out();
    end

    // hang guard, well beyond the expected span
    initial begin
        #(25 * 20000);
        bad_count++;
        close_out();
    end
endmodule // tb_top
